// [hdl/capcfg_top.sv]
// apb front end holding generation settings and exposing the vector
`timescale 1ns/1ns
module capcfg_top
  import capcfg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [40:0] cap_vec
);
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        setup;
  logic        access;
  logic        hit_vec0;
  logic        hit_vec1;
  logic        hit_ctrl;
  logic        mapped;
  logic        ro_write;
  logic        ctrl_wr;
  capcfg_if    cv ();

  // ctrl: [0] aer, [3:1] lpvc, [11:4] tags, [14:12] l0s latency
  capcfg_assemble u_asm (
    .pclk    (pclk),
    .presetn (presetn),
    .aer_en  (ctrl[0]),
    .lpvc    (ctrl[3:1]),
    .tags    (ctrl[11:4]),
    .l0s_lat (ctrl[14:12]),
    .cv      (cv)
  );

  // one decode shared by the error and write paths; the read path decodes paddr in its own case
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hit_vec0 = (paddr == ADDR_VEC0);
  assign hit_vec1 = (paddr == ADDR_VEC1);
  assign hit_ctrl = (paddr == ADDR_CTRL);
  assign mapped   = hit_vec0 || hit_vec1 || hit_ctrl;
  assign ro_write = pwrite && !hit_ctrl;
  assign ctrl_wr  = access && pwrite && hit_ctrl;
  assign pready   = 1'b1;
  assign cap_vec  = cv.vec;

  // only field bits are kept, so unused ctrl bits always read zero
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl = {17'h0, pwdata[14:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // read data registered in setup so it is stable through the access phase
  always_comb begin
    next_prdata = prdata;
    if (setup) begin
      case (paddr)
        ADDR_VEC0: next_prdata = cv.vec[31:0];
        ADDR_VEC1: next_prdata = {23'h0, cv.vec[40:32]};
        ADDR_CTRL: next_prdata = ctrl;
        default:   next_prdata = ERR_WORD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ERR_WORD;
    end else begin
      prdata <= next_prdata;
    end
  end

  // error decided in setup too; a refused write never reaches ctrl
  always_comb begin
    next_pslverr = pslverr;
    if (setup) begin
      next_pslverr = !mapped || ro_write;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pslverr;
    end
  end

  // register bus checks
  ready_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready == 1'b1)
    else $error("ready dropped");

  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr |=> ctrl == {17'h0, $past(pwdata[14:0])})
    else $error("ctrl write lost");

  ctrl_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_wr |=> ctrl == $past(ctrl))
    else $error("ctrl changed without write");

  idle_no_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    !psel |=> ctrl == $past(ctrl))
    else $error("ctrl changed while idle");

  ro_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && !hit_ctrl |=> ctrl == $past(ctrl))
    else $error("refused write reached ctrl");

  ctrl_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[31:15] == 17'h0)
    else $error("ctrl upper bits set");

  rd_vec0_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && hit_vec0 |=> prdata == $past(cv.vec[31:0]))
    else $error("vec0 read data wrong");

  rd_vec1_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && hit_vec1 |=> prdata == {23'h0, $past(cv.vec[40:32])})
    else $error("vec1 read data wrong");

  rd_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && hit_ctrl |=> prdata == $past(ctrl))
    else $error("ctrl read data wrong");

  rd_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> prdata == ERR_WORD)
    else $error("unmapped read data not zero");

  err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> pslverr)
    else $error("unmapped access not refused");

  err_rowrite_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && mapped && ro_write |=> pslverr)
    else $error("read-only write not refused");

  err_clean_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && mapped && !ro_write |=> !pslverr)
    else $error("legal access refused");

  data_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !setup |=> $stable(prdata))
    else $error("read data moved outside setup");

  err_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !setup |=> $stable(pslverr))
    else $error("error moved outside setup");

  // vector field checks at the pins
  pme_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[POS_PMECLK-VEC_LO] == 1'b0)
    else $error("pme clock bit set");

  dsi_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[POS_DSI-VEC_LO] == 1'b0)
    else $error("dsi bit set");

  aux_cur_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[POS_AUX-VEC_LO +: 3] == 3'h0)
    else $error("aux current field set");

  d1_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[POS_D1-VEC_LO] == 1'b0)
    else $error("d1 support set");

  d2_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[POS_D2-VEC_LO] == 1'b0)
    else $error("d2 support set");

  pme_states_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[POS_PME-VEC_LO +: 5] == 5'h00)
    else $error("pme state support set");

  aer_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[POS_AER-VEC_LO] == $past(ctrl[0]))
    else $error("aer bit does not follow ctrl");

  lpvc_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[POS_LPVC-VEC_LO +: 3] == $past(ctrl[3:1]))
    else $error("lpvc field does not follow ctrl");

  arb_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[POS_ARB-VEC_LO +: 4] == ARB_CAP)
    else $error("arb field not 0001");

  ext_tag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    32'($past(ctrl[11:4])) > TAG_LIMIT |-> cap_vec[POS_EXTTAG-VEC_LO])
    else $error("ext tag clear above limit");

  ext_tag_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    32'($past(ctrl[11:4])) <= TAG_LIMIT |-> !cap_vec[POS_EXTTAG-VEC_LO])
    else $error("ext tag set at or below limit");

  l0s_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[POS_L0S-VEC_LO +: 3] == $past(ctrl[14:12]))
    else $error("l0s field does not follow ctrl");

  version_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[POS_VER-VEC_LO +: 3] == PM_VERSION)
    else $error("version field not 010");

  reserved_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap_vec[4] == 1'b0 && cap_vec[31:24] == 8'h00 && cap_vec[36:32] == 5'h00)
    else $error("reserved vector bit set");
endmodule

// [hdl/capcfg_pkg.sv]
// constants for the capability configuration field bank
// Summary of operation
// - pme clock field, vector bit 99, always reads zero
// - aux current field, bits 104:102, always zero
// - d1 support bit 105 and d2 support bit 106 both zero
// - pme support for d0..d3cold, bits 107..111, all zero
// - bit 112 reports whether advanced error reporting is present
// - bits 115:113 carry the low-priority virtual channel count
// - bits 119:116 arbitration capability constantly 0001
// - bit 133 set when configured tag count exceeds 32
// - bits 98:96 power management version constantly 010
package capcfg_pkg;
  localparam int unsigned VEC_LO      = 96;
  localparam int unsigned VEC_HI      = 136;
  localparam int unsigned VEC_W       = VEC_HI - VEC_LO + 1;
  localparam int unsigned POS_VER     = 96;
  localparam int unsigned POS_PMECLK  = 99;
  localparam int unsigned POS_DSI     = 101;
  localparam int unsigned POS_AUX     = 102;
  localparam int unsigned POS_D1      = 105;
  localparam int unsigned POS_D2      = 106;
  localparam int unsigned POS_PME     = 107;
  localparam int unsigned POS_AER     = 112;
  localparam int unsigned POS_LPVC    = 113;
  localparam int unsigned POS_ARB     = 116;
  localparam int unsigned POS_EXTTAG  = 133;
  localparam int unsigned POS_L0S     = 134;
  localparam logic [2:0]  PM_VERSION  = 3'h2;
  localparam logic [3:0]  ARB_CAP     = 4'h1;
  localparam int unsigned TAG_LIMIT   = 32;
  localparam logic [11:0] ADDR_VEC0   = 12'h000;
  localparam logic [11:0] ADDR_VEC1   = 12'h004;
  localparam logic [11:0] ADDR_CTRL   = 12'h008;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] ERR_WORD    = 32'h0000_0000;
endpackage

// [hdl/capcfg_if.sv]
// carries the assembled vector from the assembler to the bus front end
`timescale 1ns/1ns
interface capcfg_if;
  logic [40:0] vec;
  modport src (output vec);
  modport dst (input vec);
endinterface

// [hdl/capcfg_assemble.sv]
// assembles the capability configuration vector bits 136:96
`timescale 1ns/1ns
module capcfg_assemble
  import capcfg_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       aer_en,
  input  wire logic [2:0] lpvc,
  input  wire logic [7:0] tags,
  input  wire logic [2:0] l0s_lat,
  capcfg_if.src           cv
);
  logic [40:0] next_vec;
  always_comb begin
    next_vec = '0;
    next_vec[POS_VER-VEC_LO +: 3]    = PM_VERSION;
    next_vec[POS_PMECLK-VEC_LO]      = 1'b0;
    next_vec[POS_DSI-VEC_LO]         = 1'b0;
    next_vec[POS_AUX-VEC_LO +: 3]    = 3'h0;
    next_vec[POS_D1-VEC_LO]          = 1'b0;
    next_vec[POS_D2-VEC_LO]          = 1'b0;
    next_vec[POS_PME-VEC_LO +: 5]    = 5'h00;
    next_vec[POS_AER-VEC_LO]         = aer_en;
    next_vec[POS_LPVC-VEC_LO +: 3]   = lpvc;
    next_vec[POS_ARB-VEC_LO +: 4]    = ARB_CAP;
    next_vec[POS_EXTTAG-VEC_LO]      = (32'(tags) > TAG_LIMIT);
    next_vec[POS_L0S-VEC_LO +: 3]    = l0s_lat;
  end
  // registered so a mid-access config write never glitches read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // fixed fields hold their constants even in reset
      cv.vec <= {17'h0, ARB_CAP, 17'h0, PM_VERSION};
    end else begin
      cv.vec <= next_vec;
    end
  end
  ver_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    cv.vec[2:0] == PM_VERSION) else $error("version field not 010");
  pm_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    cv.vec[15:3] == 13'h0) else $error("pm bits not zero");
  arb_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    cv.vec[23:20] == ARB_CAP) else $error("arb field wrong");
  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    cv.vec[36:24] == 13'h0) else $error("reserved bits set");
  ext_tag_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> cv.vec[37] == ($past(tags) > 8'd32)) else $error("ext tag wrong");
  aer_track_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> cv.vec[16] == $past(aer_en)) else $error("aer bit wrong");
  lpvc_track_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> cv.vec[19:17] == $past(lpvc)) else $error("lpvc field wrong");
  l0s_track_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> cv.vec[40:38] == $past(l0s_lat)) else $error("l0s field wrong");
endmodule

// [verif/cfg_host.sv]
// apb master standing in for host configuration software
`timescale 1ns/1ns
module cfg_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    // released data flips so a stale value can never pass
    {psel, penable, pwdata} <= {2'b00, ~d};
    // idle edge so a following call never drives psel twice in one step
    @(posedge pclk);
  endtask
endmodule

// [verif/test_pcie_capability_config_fields.sv]
// register and vector tests for the capability field bank
`timescale 1ns/1ns
module test_pcie_capability_config_fields
  import capcfg_pkg::*;
;
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, c;
  logic [40:0] cap_vec, x;
  logic        e;
  int          mismatches = 0, checks = 0;
  always #2 pclk = ~pclk;
  capcfg_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_vec(cap_vec));
  cfg_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic cmp(input string n, input logic [40:0] xv, input logic [40:0] g);
    checks++;
    if (g !== xv) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, xv, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    cmp("reset vector", 41'h0010_0002, cap_vec);
    presetn <= 1'b1;
    @(posedge pclk);
    host.xfer(1'b1, ADDR_VEC0, 32'hffff_ffff, q, e);
    cmp("ro write error", 41'h1, 41'(e));
    host.xfer(1'b0, 12'h00c, 32'h0, q, e);
    cmp("unmapped error", 41'h1, 41'(e));
    cmp("unmapped data", 41'h0, 41'(q));
    // every latency code once; tag counts 31..38 straddle the limit of 32
    for (int i = 0; i < 8; i++) begin
      c = {17'h0, i[2:0], 8'(31 + i), i[2:0], i[0]};
      x = 41'h0010_0002 | (41'(i[0]) << 16) | (41'(i[2:0]) << 17) | (41'(i > 1) << 37) | (41'(i[2:0]) << 38);
      host.xfer(1'b1, ADDR_CTRL, c, q, e);
      cmp("ctrl write error", 41'h0, 41'(e));
      repeat (2) @(negedge pclk);
      cmp("vector", x, cap_vec);
      @(posedge pclk);
      host.xfer(1'b0, ADDR_VEC0, 32'h0, q, e);
      cmp("vec0", 41'(x[31:0]), 41'(q));
      cmp("vec0 error", 41'h0, 41'(e));
      host.xfer(1'b0, ADDR_VEC1, 32'h0, q, e);
      cmp("vec1", 41'(x[40:32]), 41'(q));
      host.xfer(1'b0, ADDR_CTRL, 32'h0, q, e);
      cmp("ctrl", 41'(c), 41'(q));
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp("mid reset vector", 41'h0010_0002, cap_vec);
    presetn <= 1'b1;
    @(posedge pclk);
    host.xfer(1'b0, ADDR_CTRL, 32'h0, q, e);
    cmp("ctrl after reset", 41'h0, 41'(q));
    stop_test();
  end
  initial begin
    #20000;
    mismatches++;
    stop_test();
  end
endmodule
